// >>> verilog/dacc_pkg.sv
// Package: register map, fields and constants of the dual channel control
package dacc_pkg;
  // Register offsets (byte addresses, one word each)
  localparam logic [7:0] OFS_A_RATE   = 8'h00;
  localparam logic [7:0] OFS_A_CMD    = 8'h04;
  localparam logic [7:0] OFS_A_QUEUE  = 8'h08;
  localparam logic [7:0] OFS_B_RATE   = 8'h0C;
  localparam logic [7:0] OFS_B_CMD    = 8'h10;
  localparam logic [7:0] OFS_B_QUEUE  = 8'h14;
  localparam logic [7:0] OFS_CHANGE   = 8'h18;
  localparam logic [7:0] OFS_AUX      = 8'h1C;
  localparam logic [7:0] OFS_ISTAT    = 8'h20;
  localparam logic [7:0] OFS_A_STAT   = 8'h24;
  localparam logic [7:0] OFS_B_STAT   = 8'h28;
  // Reset values
  localparam logic [7:0] RST_RATE     = 8'h00;
  localparam logic [7:0] RST_AUX      = 8'h00;
  // Field positions
  localparam int RX_LO   = 0;
  localparam int TX_LO   = 2;
  localparam int MISC_LO = 4;
  localparam int TABLE_BIT = 7;
  // Miscellaneous command codes
  localparam logic [3:0] MC_PTR_ONE  = 4'h1;
  localparam logic [3:0] MC_RST_RX   = 4'h2;
  localparam logic [3:0] MC_RST_TX   = 4'h3;
  localparam logic [3:0] MC_RST_ERR  = 4'h4;
  localparam logic [3:0] MC_RST_BRK  = 4'h5;
  localparam logic [3:0] MC_BRK_ON   = 4'h6;
  localparam logic [3:0] MC_BRK_OFF  = 4'h7;
  localparam logic [3:0] MC_RTS_ON   = 4'h8;
  localparam logic [3:0] MC_RTS_OFF  = 4'h9;
  localparam logic [3:0] MC_TMO_ON   = 4'hA;
  localparam logic [3:0] MC_PTR_ZERO = 4'hB;
  localparam logic [3:0] MC_TMO_OFF  = 4'hC;
  localparam logic [3:0] MC_PWR_DOWN = 4'hE;
  localparam logic [3:0] MC_PWR_UP   = 4'hF;
  // Enable/disable field codes
  localparam logic [1:0] EN_CODE  = 2'h1;
  localparam logic [1:0] DIS_CODE = 2'h2;
  // Rate codes that bypass the table
  localparam logic [3:0] RATE_TIMER = 4'hE;
  localparam logic [3:0] RATE_EXT   = 4'hF;
  // Break timing in bit times
  localparam int BRK_BITS = 2;
  // Per-channel command strobes
  typedef struct packed {
    logic rx_en;
    logic rx_dis;
    logic tx_en;
    logic tx_dis;
    logic [3:0] misc;
  } dacc_cmd_t;
  // Effective rate selection of one direction
  typedef struct packed {
    logic       use_timer;
    logic       use_ext;
    logic       table_two;
    logic [3:0] code;
  } dacc_rate_t;
endpackage

// >>> verilog/dacc_top.sv
// Command, rate select, queues, input change and auxiliary control logic
// Functional notes
// [RULE1] Rate select: low nibble transmit rate code, high nibble receive code.
// [RULE2] Codes 1110 and 1111 ignore extended table bits and table set bit.
// [RULE3] One command write acts on receiver, transmitter and misc together.
// [RULE4] Command bits 1-0: 01 enable receiver, 10 disable, else nothing.
// [RULE5] Command bits 3-2: 01 enable transmitter, 10 disable, else nothing.
// [RULE6] Code 0001 points mode pointer at one; code 1011 at zero.
// [RULE7] 0010 disables and flushes receiver; 0011 disables, flushes transmitter.
// [RULE8] Code 0100 clears break, parity and overrun error flags.
// [RULE9] Code 0101 clears break change flag, bit 2 or bit 6.
// [RULE10] 0110 holds line low when transmitter enabled, after queue; 0111 ends.
// [RULE11] Code 1000 drives request to send low; 1001 drives it high.
// [RULE12] 1010 enters timeout mode: counter stopped, ready cleared, restarts.
// [RULE13] 1100 leaves timeout mode without stopping counter or clearing ready.
// [RULE14] 1110 on channel A only stops oscillator, keeps registers.
// [RULE15] Host writes only power up command while powered down.
// [RULE16] 1111 on channel A only restarts oscillator; host then waits.
// [RULE17] Receive and transmit queues of parameter depth, one char at a time.
// [RULE18] Change report: levels low nibble, change flags high, cleared by read.
// [RULE19] Aux bits 3-0 enable input changes to set interrupt status bit 7.
// [RULE20] Aux bits 6-4 select counter/timer mode and clock source.
// [RULE21] Host changes counter/timer mode only while counter stopped.
// [RULE22] Aux bit 7 selects table set; change after channels reset.
// [RULE23] Break change flag sets on receiver break start or end.
// [RULE24] Reserved command encodings change no channel state.
//
// Implementation choices: the register offsets and register access over APB.
`timescale 1ns/1ps
module dacc_top #(
  parameter int DEPTH = 8,
  parameter int AW    = $clog2(DEPTH)
) (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [1:0]  rx_char_valid,
  input  wire logic [15:0] rx_char_data,
  input  wire logic [1:0]  rx_break_edge,
  input  wire logic [1:0]  rx_parity_err,
  input  wire logic [1:0]  rx_overrun,
  input  wire logic [1:0]  tx_shift_idle,
  output logic [1:0]       tx_shift_load,
  output logic [15:0]      tx_shift_data,
  input  wire logic [1:0]  bit_tick,
  input  wire logic [3:0]  input_pins,
  output logic [1:0]       rx_enabled,
  output logic [1:0]       tx_enabled,
  output logic [1:0]       break_out,
  output logic [1:0]       rts_n,
  output logic [1:0]       mode_ptr_one,
  output logic [1:0]       timeout_mode,
  output logic             ct_restart,
  output logic             ct_force_stop,
  output logic             ct_ready_clr,
  output logic             osc_stopped,
  output logic [2:0]       ct_mode_sel,
  output logic [1:0]       input_change_irq,
  output dacc_pkg::dacc_rate_t [1:0] tx_rate,
  output dacc_pkg::dacc_rate_t [1:0] rx_rate
);
  // ************************************************
  // Bus decode
  // ************************************************
  logic       wr;
  logic       rd;
  logic [7:0] wb;
  assign pready  = 1'b1;
  assign wr      = psel && penable && pwrite;
  assign rd      = psel && penable && !pwrite;
  assign wb      = pwdata[7:0];
  assign pslverr = psel && penable &&
                   (paddr > dacc_pkg::OFS_B_STAT || paddr[1:0] != 2'b00);

  logic [7:0] rate_r [2];
  logic [7:0] aux_r;
  logic [3:0] pin_r;
  logic [3:0] chg_r;
  logic [7:0] istat_r;
  logic [2:0] err_r [2];
  dacc_pkg::dacc_cmd_t cmd [2];
  logic [1:0] cmd_wr;
  logic [1:0] q_wr;
  logic [1:0] q_rd;
  logic [7:0] rx_head [2];
  logic [AW:0] rx_cnt [2];
  logic [AW:0] tx_cnt [2];

  assign cmd_wr[0] = wr && paddr == dacc_pkg::OFS_A_CMD;
  assign cmd_wr[1] = wr && paddr == dacc_pkg::OFS_B_CMD;
  assign q_wr[0]   = wr && paddr == dacc_pkg::OFS_A_QUEUE;
  assign q_wr[1]   = wr && paddr == dacc_pkg::OFS_B_QUEUE;
  assign q_rd[0]   = rd && paddr == dacc_pkg::OFS_A_QUEUE;
  assign q_rd[1]   = rd && paddr == dacc_pkg::OFS_B_QUEUE;

  // ************************************************
  // Command decode per channel
  // ************************************************
  // Power down gates commands; only power-up on channel A passes
  genvar c;
  generate
    for (c = 0; c < 2; c++) begin : g_cmd
      logic go;
      assign go = cmd_wr[c] &&
        (!osc_stopped || (c == 0 && wb[7:4] == dacc_pkg::MC_PWR_UP));
      assign cmd[c].rx_en  = go && wb[1:0] == dacc_pkg::EN_CODE;  // RULE4
      assign cmd[c].rx_dis = go && wb[1:0] == dacc_pkg::DIS_CODE; // RULE4
      assign cmd[c].tx_en  = go && wb[3:2] == dacc_pkg::EN_CODE;  // RULE5
      assign cmd[c].tx_dis = go && wb[3:2] == dacc_pkg::DIS_CODE; // RULE5
      assign cmd[c].misc   = go ? wb[7:4] : 4'h0; // RULE3 RULE24
    end
  endgenerate

  // ************************************************
  // Channel state
  // ************************************************
  logic [1:0] brk_req_r;
  logic [1:0] brk_cnt_r [2];
  generate
    for (c = 0; c < 2; c++) begin : g_chan
      logic [3:0] m;
      assign m = cmd[c].misc;
      always_ff @(posedge clk) begin
        if (reset) begin
          rx_enabled[c] <= 1'b0;
        end else if (cmd[c].rx_dis || m == dacc_pkg::MC_RST_RX) begin
          rx_enabled[c] <= 1'b0; // RULE7
        end else if (cmd[c].rx_en) begin
          rx_enabled[c] <= 1'b1; // RULE4
        end
      end
      always_ff @(posedge clk) begin
        if (reset) begin
          tx_enabled[c] <= 1'b0;
        end else if (cmd[c].tx_dis || m == dacc_pkg::MC_RST_TX) begin
          tx_enabled[c] <= 1'b0; // RULE7
        end else if (cmd[c].tx_en) begin
          tx_enabled[c] <= 1'b1; // RULE5
        end
      end
      always_ff @(posedge clk) begin
        if (reset) begin
          mode_ptr_one[c] <= 1'b1;
        end else if (m == dacc_pkg::MC_PTR_ONE) begin
          mode_ptr_one[c] <= 1'b1; // RULE6
        end else if (m == dacc_pkg::MC_PTR_ZERO) begin
          mode_ptr_one[c] <= 1'b0; // RULE6
        end
      end
      always_ff @(posedge clk) begin
        if (reset) begin
          rts_n[c] <= 1'b1;
        end else if (m == dacc_pkg::MC_RTS_ON) begin
          rts_n[c] <= 1'b0; // RULE11
        end else if (m == dacc_pkg::MC_RTS_OFF) begin
          rts_n[c] <= 1'b1; // RULE11
        end
      end
      always_ff @(posedge clk) begin
        if (reset) begin
          timeout_mode[c] <= 1'b0;
        end else if (m == dacc_pkg::MC_TMO_ON) begin
          timeout_mode[c] <= 1'b1; // RULE12
        end else if (m == dacc_pkg::MC_TMO_OFF) begin
          timeout_mode[c] <= 1'b0; // RULE13
        end
      end
      // Error flags: break, parity, overrun; new events win over clear
      always_ff @(posedge clk) begin
        if (reset) begin
          err_r[c] <= 3'h0;
        end else begin
          err_r[c] <= ((m == dacc_pkg::MC_RST_ERR) ? 3'h0 : err_r[c]) | // RULE8
                      {rx_break_edge[c], rx_parity_err[c], rx_overrun[c]};
        end
      end
      // Break request; break output clears at the next bit tick, sets at a bit tick once transmit queue and shifter are empty
      always_ff @(posedge clk) begin
        if (reset) begin
          brk_req_r[c] <= 1'b0;
        end else if (m == dacc_pkg::MC_BRK_ON && tx_enabled[c]) begin
          brk_req_r[c] <= 1'b1; // RULE10
        end else if (m == dacc_pkg::MC_BRK_OFF ||
                     m == dacc_pkg::MC_RST_TX) begin
          brk_req_r[c] <= 1'b0; // RULE10
        end
      end
      always_ff @(posedge clk) begin
        if (reset) begin
          brk_cnt_r[c] <= 2'h0;
          break_out[c] <= 1'b0;
        end else if (!brk_req_r[c]) begin
          brk_cnt_r[c] <= 2'h0;
          if (bit_tick[c]) begin
            break_out[c] <= 1'b0; // RULE10
          end
        end else if (tx_cnt[c] == '0 && tx_shift_idle[c]) begin
          if (bit_tick[c] && brk_cnt_r[c] != 2'(dacc_pkg::BRK_BITS)) begin
            brk_cnt_r[c] <= brk_cnt_r[c] + 2'h1;
          end
          if (bit_tick[c]) begin
            break_out[c] <= 1'b1; // RULE10
          end
        end
      end
      // Rate selection
      always_comb begin
        tx_rate[c].code      = rate_r[c][3:0]; // RULE1
        tx_rate[c].use_timer = rate_r[c][3:0] == dacc_pkg::RATE_TIMER;
        tx_rate[c].use_ext   = rate_r[c][3:0] == dacc_pkg::RATE_EXT;
        tx_rate[c].table_two = aux_r[dacc_pkg::TABLE_BIT] &&
                               !(rate_r[c][3:1] == 3'h7); // RULE2
        rx_rate[c].code      = rate_r[c][7:4]; // RULE1
        rx_rate[c].use_timer = rate_r[c][7:4] == dacc_pkg::RATE_TIMER;
        rx_rate[c].use_ext   = rate_r[c][7:4] == dacc_pkg::RATE_EXT;
        rx_rate[c].table_two = aux_r[dacc_pkg::TABLE_BIT] &&
                               !(rate_r[c][7:5] == 3'h7); // RULE2
      end
      always_ff @(posedge clk) begin
        if (reset) begin
          rate_r[c] <= dacc_pkg::RST_RATE;
        end else if (wr && paddr == (c == 0 ? dacc_pkg::OFS_A_RATE
                                            : dacc_pkg::OFS_B_RATE)) begin
          rate_r[c] <= wb; // RULE1
        end
      end
      // Queues
      logic [7:0]  rxm [DEPTH];
      logic [7:0]  txm [DEPTH];
      logic [AW-1:0] rwp, rrp, twp, trp;
      logic rx_push, rx_pop, tx_push, tx_pop, rx_flush, tx_flush;
      assign rx_flush = m == dacc_pkg::MC_RST_RX;
      assign tx_flush = m == dacc_pkg::MC_RST_TX;
      assign rx_push  = rx_char_valid[c] && rx_enabled[c] &&
                        rx_cnt[c] != (AW+1)'(DEPTH);
      assign rx_pop   = q_rd[c] && rx_cnt[c] != '0;
      assign tx_push  = q_wr[c] && tx_cnt[c] != (AW+1)'(DEPTH);
      assign tx_pop   = tx_enabled[c] && tx_shift_idle[c] &&
                        tx_cnt[c] != '0 && !tx_shift_load[c];
      assign rx_head[c] = rxm[rrp];
      always_ff @(posedge clk) begin
        if (rx_push) begin
          rxm[rwp] <= rx_char_data[c*8 +: 8]; // RULE17
        end
        if (tx_push) begin
          txm[twp] <= wb;
        end
      end
      always_ff @(posedge clk) begin
        if (reset || rx_flush) begin
          rwp <= '0;
          rrp <= '0;
          rx_cnt[c] <= '0; // RULE7
        end else begin
          if (rx_push) rwp <= AW'((rwp + 1) % DEPTH);
          if (rx_pop)  rrp <= AW'((rrp + 1) % DEPTH);
          rx_cnt[c] <= rx_cnt[c] + (AW+1)'(rx_push) - (AW+1)'(rx_pop);
        end
      end
      always_ff @(posedge clk) begin
        if (reset || tx_flush) begin
          twp <= '0;
          trp <= '0;
          tx_cnt[c] <= '0; // RULE7
          tx_shift_load[c] <= 1'b0;
          tx_shift_data[c*8 +: 8] <= 8'h00;
        end else begin
          tx_shift_load[c] <= tx_pop; // RULE17
          if (tx_pop) tx_shift_data[c*8 +: 8] <= txm[trp];
          if (tx_push) twp <= AW'((twp + 1) % DEPTH);
          if (tx_pop)  trp <= AW'((trp + 1) % DEPTH);
          tx_cnt[c] <= tx_cnt[c] + (AW+1)'(tx_push) - (AW+1)'(tx_pop);
        end
      end
    end
  endgenerate

  // ************************************************
  // Counter/timer, power down, auxiliary control
  // ************************************************
  assign ct_force_stop = cmd[0].misc == dacc_pkg::MC_TMO_ON ||
                         cmd[1].misc == dacc_pkg::MC_TMO_ON; // RULE12
  assign ct_ready_clr  = ct_force_stop; // RULE12
  assign ct_restart    = |(timeout_mode & rx_char_valid & rx_enabled); // RULE12
  assign ct_mode_sel   = aux_r[6:4]; // RULE20
  always_ff @(posedge clk) begin
    if (reset) begin
      osc_stopped <= 1'b0;
    end else if (cmd[0].misc == dacc_pkg::MC_PWR_DOWN) begin
      osc_stopped <= 1'b1; // RULE14
    end else if (cmd[0].misc == dacc_pkg::MC_PWR_UP) begin
      osc_stopped <= 1'b0; // RULE16
    end
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      aux_r <= dacc_pkg::RST_AUX; // RULE19
    end else if (wr && paddr == dacc_pkg::OFS_AUX) begin
      aux_r <= wb; // RULE22
    end
  end
  logic chg_rd;
  logic [3:0] chg_new;
  assign chg_rd  = rd && paddr == dacc_pkg::OFS_CHANGE;
  assign chg_new = pin_r ^ input_pins;
  always_ff @(posedge clk) begin
    if (reset) begin
      pin_r <= 4'h0;
      chg_r <= 4'h0;
    end else begin
      pin_r <= input_pins;
      chg_r <= (chg_rd ? 4'h0 : chg_r) | chg_new; // RULE18
    end
  end
  // Interrupt status bits handled here: 2, 6, 7
  always_ff @(posedge clk) begin
    if (reset) begin
      istat_r <= 8'h00;
    end else begin
      istat_r[2] <= (istat_r[2] && cmd[0].misc != dacc_pkg::MC_RST_BRK)
                    || rx_break_edge[0]; // RULE9 RULE23
      istat_r[6] <= (istat_r[6] && cmd[1].misc != dacc_pkg::MC_RST_BRK)
                    || rx_break_edge[1]; // RULE9 RULE23
      istat_r[7] <= (istat_r[7] && !chg_rd) ||
                    |(chg_new & aux_r[3:0]); // RULE19
    end
  end
  assign input_change_irq = {istat_r[6] | istat_r[2], istat_r[7]};

  // ************************************************
  // Read mux
  // ************************************************
  always_comb begin
    prdata = 32'h0000_0000;
    case (paddr)
      dacc_pkg::OFS_A_RATE:  prdata[7:0] = rate_r[0];
      dacc_pkg::OFS_B_RATE:  prdata[7:0] = rate_r[1];
      dacc_pkg::OFS_A_QUEUE: prdata[7:0] = rx_head[0];
      dacc_pkg::OFS_B_QUEUE: prdata[7:0] = rx_head[1];
      dacc_pkg::OFS_CHANGE:  prdata[7:0] = {chg_r, pin_r}; // RULE18
      dacc_pkg::OFS_AUX:     prdata[7:0] = aux_r;
      dacc_pkg::OFS_ISTAT:   prdata[7:0] = istat_r;
      dacc_pkg::OFS_A_STAT:  prdata[7:0] = {err_r[0], 5'h00};
      dacc_pkg::OFS_B_STAT:  prdata[7:0] = {err_r[1], 5'h00};
      default:               prdata = 32'h0000_0000;
    endcase
  end

  // ************************************************
  // Checks
  // ************************************************
  property p_rx_enable;
    @(posedge clk) disable iff (reset)
      cmd[0].rx_en && !cmd[0].rx_dis && cmd[0].misc != dacc_pkg::MC_RST_RX
      |=> rx_enabled[0];
  endproperty
  a_rx_enable: assert property (p_rx_enable) else $error("rx enable"); // RULE4
  property p_rts;
    @(posedge clk) disable iff (reset)
      cmd[1].misc == dacc_pkg::MC_RTS_ON |=> !rts_n[1];
  endproperty
  a_rts: assert property (p_rts) else $error("rts not low"); // RULE11
  property p_flush;
    @(posedge clk) disable iff (reset)
      cmd[0].misc == dacc_pkg::MC_RST_TX |=> tx_cnt[0] == '0 && !tx_enabled[0];
  endproperty
  a_flush: assert property (p_flush) else $error("tx flush"); // RULE7
  property p_chg_clear;
    @(posedge clk) disable iff (reset)
      chg_rd && chg_new == 4'h0 |=> chg_r == 4'h0;
  endproperty
  a_chg_clear: assert property (p_chg_clear) else $error("chg"); // RULE18
  property p_pwr;
    @(posedge clk) disable iff (reset)
      cmd[1].misc == dacc_pkg::MC_PWR_DOWN && cmd[0].misc == 4'h0
      |=> osc_stopped == $past(osc_stopped);
  endproperty
  a_pwr: assert property (p_pwr) else $error("b power down"); // RULE14
  property p_brk;
    @(posedge clk) disable iff (reset)
      rx_break_edge[0] |=> istat_r[2];
  endproperty
  a_brk: assert property (p_brk) else $error("break flag"); // RULE23
  property p_ptr;
    @(posedge clk) disable iff (reset)
      cmd[0].misc == dacc_pkg::MC_PTR_ZERO |=> !mode_ptr_one[0];
  endproperty
  a_ptr: assert property (p_ptr) else $error("pointer"); // RULE6
  property p_rsv;
    @(posedge clk) disable iff (reset)
      cmd_wr[0] && wb == 8'hDF && !osc_stopped
      |=> $stable(rx_enabled[0]) && $stable(tx_enabled[0]);
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved"); // RULE24
endmodule

// >>> tb/dacc_line_model.sv
// Far-side model: transmit shift registers and bit timing
`timescale 1ns/1ps
module dacc_line_model #(
  parameter int TICK = 8
) (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic [1:0]  tx_shift_load,
  input  wire logic [15:0] tx_shift_data,
  output logic [1:0]       tx_shift_idle,
  output logic [1:0]       bit_tick
);
  logic [7:0] got_a[$];
  int         div_r;
  int         busy_r[2];
  always @(posedge clk) begin
    if (reset || div_r == TICK - 1) begin
      div_r <= 0;
    end else begin
      div_r <= div_r + 1;
    end
  end
  assign bit_tick = {2{div_r == TICK - 1}};
  // Ten bit times per character
  always @(posedge clk) begin
    for (int c = 0; c < 2; c++) begin
      if (reset) begin
        busy_r[c] <= 0;
      end else if (tx_shift_load[c]) begin
        busy_r[c] <= 10;
      end else if (bit_tick[c] && busy_r[c] != 0) begin
        busy_r[c] <= busy_r[c] - 1;
      end
    end
    if (!reset && tx_shift_load[0]) begin
      got_a.push_back(tx_shift_data[7:0]);
    end
  end
  assign tx_shift_idle = {busy_r[1] == 0, busy_r[0] == 0};
endmodule

// >>> tb/tb.sv
// Self-checking bench of the dual channel control block
`timescale 1ns/1ps
module tb;
  localparam int TICK = 8;
  logic        clk, reset, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0]  rx_char_valid, rx_break_edge, rx_parity_err, rx_overrun;
  logic [1:0]  tx_shift_idle, tx_shift_load, bit_tick, rx_enabled;
  logic [1:0]  tx_enabled, break_out, rts_n, mode_ptr_one, timeout_mode;
  logic [1:0]  input_change_irq;
  logic [15:0] rx_char_data, tx_shift_data;
  logic [3:0]  input_pins;
  logic        ct_restart, ct_force_stop, ct_ready_clr, osc_stopped, err;
  logic [2:0]  ct_mode_sel;
  logic [31:0] rd_q;
  logic        err_q;
  logic [2:0]  ct_seen;
  dacc_pkg::dacc_rate_t [1:0] tx_rate, rx_rate;
  int          n_mismatch, checked, cycles;
  dacc_top #(.DEPTH(8)) u_dacc_top (.clk(clk), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_char_valid(rx_char_valid), .rx_char_data(rx_char_data),
    .rx_break_edge(rx_break_edge), .rx_parity_err(rx_parity_err),
    .rx_overrun(rx_overrun), .tx_shift_idle(tx_shift_idle),
    .tx_shift_load(tx_shift_load), .tx_shift_data(tx_shift_data),
    .bit_tick(bit_tick), .input_pins(input_pins), .rx_enabled(rx_enabled),
    .tx_enabled(tx_enabled), .break_out(break_out), .rts_n(rts_n),
    .mode_ptr_one(mode_ptr_one), .timeout_mode(timeout_mode),
    .ct_restart(ct_restart), .ct_force_stop(ct_force_stop),
    .ct_ready_clr(ct_ready_clr), .osc_stopped(osc_stopped),
    .ct_mode_sel(ct_mode_sel), .input_change_irq(input_change_irq),
    .tx_rate(tx_rate), .rx_rate(rx_rate));
  dacc_line_model #(.TICK(TICK)) u_dacc_line_model (.clk(clk),
    .reset(reset), .tx_shift_load(tx_shift_load),
    .tx_shift_data(tx_shift_data), .tx_shift_idle(tx_shift_idle),
    .bit_tick(bit_tick));
  // ************************************************************
  // Bus and check tasks
  // ************************************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
    rd = rd_q;
    err = err_q;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  task automatic pulse(input logic [7:0] v, input logic [15:0] d);
    @(posedge clk);
    {rx_break_edge, rx_overrun, rx_parity_err, rx_char_valid} <= v;
    rx_char_data <= d;
    @(posedge clk);
    {rx_break_edge, rx_overrun, rx_parity_err, rx_char_valid} <= 8'h00;
    #1;
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial clk = 1'b0;
  always #10 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      finish_test();
    end
  end
  // Bus answer at each edge; counter/timer strobes accumulated since reset
  always @(posedge clk) begin
    rd_q <= prdata;
    err_q <= pslverr;
    ct_seen <= reset ? 3'h0
               : ct_seen | {ct_restart, ct_ready_clr, ct_force_stop};
  end
  // ************************************************************
  // Sequence
  // ************************************************************
  initial begin
    {n_mismatch, checked, cycles} = '0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {rx_break_edge, rx_overrun, rx_parity_err, rx_char_valid} = 8'h00;
    rx_char_data = 16'h0000;
    input_pins = 4'h0;
    reset = 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    #1;
    chk({rts_n, mode_ptr_one}, 4'hF);
    rdchk(dacc_pkg::OFS_AUX, 32'h0);
    wr(dacc_pkg::OFS_A_RATE, 32'hA5);
    chk({tx_rate[0], rx_rate[0]}, {7'h05, 7'h0A});
    rdchk(dacc_pkg::OFS_A_RATE, 32'hA5);
    wr(dacc_pkg::OFS_AUX, 32'h80);
    chk(tx_rate[0], 7'h15);
    wr(dacc_pkg::OFS_A_RATE, 32'hAA);
    chk({tx_rate[0], rx_rate[0]}, {7'h1A, 7'h1A});
    wr(dacc_pkg::OFS_A_RATE, 32'hFE);
    chk({tx_rate[0], rx_rate[0]}, {7'h4E, 7'h2F});
    wr(dacc_pkg::OFS_A_CMD, 32'h85);
    chk({rts_n[0], tx_enabled[0], rx_enabled[0]}, 3'b011);
    wr(dacc_pkg::OFS_A_CMD, 32'h9A);
    chk({rts_n[0], tx_enabled[0], rx_enabled[0]}, 3'b100);
    wr(dacc_pkg::OFS_A_CMD, 32'h05);
    wr(dacc_pkg::OFS_A_CMD, 32'hDF);
    chk({tx_enabled[0], rx_enabled[0]}, 2'b11);
    wr(dacc_pkg::OFS_B_CMD, 32'hB0);
    chk(mode_ptr_one, 2'b01);
    wr(dacc_pkg::OFS_B_CMD, 32'h10);
    chk(mode_ptr_one, 2'b11);
    // Queued characters held back while transmitter off
    wr(dacc_pkg::OFS_A_CMD, 32'h08);
    for (int i = 1; i < 4; i++) wr(dacc_pkg::OFS_A_QUEUE, 32'h11 * i);
    wait_cyc(3 * TICK);
    chk(u_dacc_line_model.got_a.size(), 0);
    wr(dacc_pkg::OFS_A_CMD, 32'h04);
    wait_cyc(40 * TICK);
    chk(u_dacc_line_model.got_a.size(), 3);
    for (int i = 0; i < 3; i++) begin
      chk(u_dacc_line_model.got_a[i], 8'h11 * (i + 1));
    end
    wr(dacc_pkg::OFS_A_CMD, 32'h08);
    wr(dacc_pkg::OFS_A_QUEUE, 32'h44);
    wr(dacc_pkg::OFS_A_CMD, 32'h30);
    chk(tx_enabled[0], 1'b0);
    wr(dacc_pkg::OFS_A_CMD, 32'h04);
    wait_cyc(20 * TICK);
    chk(u_dacc_line_model.got_a.size(), 3);
    wr(dacc_pkg::OFS_A_CMD, 32'h60);
    wait_cyc(2 * TICK + 1);
    chk(break_out[0], 1'b1);
    wr(dacc_pkg::OFS_A_CMD, 32'h70);
    wait_cyc(2 * TICK + 1);
    chk(break_out[0], 1'b0);
    wr(dacc_pkg::OFS_A_CMD, 32'h08);
    wr(dacc_pkg::OFS_A_CMD, 32'h60);
    wait_cyc(2 * TICK + 1);
    chk(break_out[0], 1'b0);
    wr(dacc_pkg::OFS_A_CMD, 32'h71);
    for (int i = 0; i < 3; i++) begin
      pulse(8'h01, 16'h00A1 + 16'(i));
    end
    rdchk(dacc_pkg::OFS_A_QUEUE, 32'hA1);
    wr(dacc_pkg::OFS_A_CMD, 32'h20);
    chk(rx_enabled[0], 1'b0);
    wr(dacc_pkg::OFS_A_CMD, 32'h01);
    pulse(8'h01, 16'h0077);
    rdchk(dacc_pkg::OFS_A_QUEUE, 32'h77);
    wr(dacc_pkg::OFS_A_CMD, 32'hA0);
    chk(timeout_mode, 2'b01);
    chk(ct_seen, 3'b011);
    pulse(8'h01, 16'h0055);
    chk(ct_seen, 3'b111);
    wr(dacc_pkg::OFS_A_CMD, 32'hC0);
    chk(timeout_mode, 2'b00);
    pulse(8'h14, 16'h0000);
    rdchk(dacc_pkg::OFS_A_STAT, 32'h60);
    wr(dacc_pkg::OFS_A_CMD, 32'h40);
    rdchk(dacc_pkg::OFS_A_STAT, 32'h0);
    pulse(8'hC0, 16'h0000);
    chk(input_change_irq[1], 1'b1);
    rdchk(dacc_pkg::OFS_ISTAT, 32'h44);
    wr(dacc_pkg::OFS_B_CMD, 32'h50);
    rdchk(dacc_pkg::OFS_ISTAT, 32'h04);
    rdchk(dacc_pkg::OFS_B_STAT, 32'h80);
    wr(dacc_pkg::OFS_A_CMD, 32'h50);
    rdchk(dacc_pkg::OFS_ISTAT, 32'h0);
    wr(dacc_pkg::OFS_AUX, 32'h01);
    @(posedge clk) input_pins <= 4'h5;
    wait_cyc(4);
    chk(input_change_irq[0], 1'b1);
    rdchk(dacc_pkg::OFS_ISTAT, 32'h80);
    rdchk(dacc_pkg::OFS_CHANGE, 32'h55);
    rdchk(dacc_pkg::OFS_CHANGE, 32'h05);
    wr(dacc_pkg::OFS_AUX, 32'h00);
    @(posedge clk) input_pins <= 4'h4;
    wait_cyc(4);
    chk(input_change_irq[0], 1'b0);
    rdchk(dacc_pkg::OFS_CHANGE, 32'h14);
    for (int i = 0; i < 8; i++) begin
      wr(dacc_pkg::OFS_AUX, i << 4);
      chk(ct_mode_sel, i[2:0]);
    end
    wr(dacc_pkg::OFS_B_CMD, 32'hE0);
    chk(osc_stopped, 1'b0);
    wr(dacc_pkg::OFS_A_CMD, 32'h0A);
    wr(dacc_pkg::OFS_A_CMD, 32'hE0);
    chk(osc_stopped, 1'b1);
    rdchk(dacc_pkg::OFS_A_RATE, 32'hFE);
    wr(dacc_pkg::OFS_B_CMD, 32'h80);
    chk(rts_n[1], 1'b1);
    wr(dacc_pkg::OFS_A_CMD, 32'hF0);
    chk(osc_stopped, 1'b0);
    wait_cyc(50);
    apb(1'b0, 8'h30, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    finish_test();
  end
endmodule
